// File: acc_pkg.sv
// constants for the analog comparator control block
// assumes a 32-bit AXI4-Lite register bus and one system clock
////////////////////////////////////////////////////////////////////////////////
`default_nettype none
package acc_pkg;
    localparam int          ACC_ADDR_W          = 8;
    localparam int          ACC_DATA_W          = 32;
    localparam int          ACC_REG_W           = 8;
    // register byte offsets
    localparam logic [7:0]  ACC_OFS_CTRL_STATUS = 8'h50;
    localparam logic [7:0]  ACC_OFS_CONV_B      = 8'h54;
    localparam logic [7:0]  ACC_OFS_PIN_DIS     = 8'h58;
    // comparator_control_status fields
    localparam int          ACC_BIT_POWER_OFF   = 7;
    localparam int          ACC_BIT_BANDGAP     = 6;
    localparam int          ACC_BIT_RESULT      = 5;
    localparam int          ACC_BIT_IRQ_FLAG    = 4;
    localparam int          ACC_BIT_IRQ_EN      = 3;
    localparam int          ACC_BIT_CAPTURE     = 2;
    localparam int          ACC_BIT_MODE_HI     = 1;
    localparam int          ACC_BIT_MODE_LO     = 0;
    // converter_control_status_b and pin disable fields
    localparam int          ACC_BIT_MUX_EN      = 6;
    localparam int          ACC_BIT_NEG_OFF     = 1;
    localparam int          ACC_BIT_POS_OFF     = 0;
    // reset values
    localparam logic [7:0]  ACC_RST_CTRL        = 8'h00;
    localparam logic        ACC_RST_MUX_EN      = 1'b0;
    localparam logic [1:0]  ACC_RST_PIN_DIS     = 2'b00;
    // interrupt modes
    localparam logic [1:0]  ACC_MODE_TOGGLE     = 2'b00;
    localparam logic [1:0]  ACC_MODE_RESERVED   = 2'b01;
    localparam logic [1:0]  ACC_MODE_FALL       = 2'b10;
    localparam logic [1:0]  ACC_MODE_RISE       = 2'b11;
    // bus responses
    localparam logic [1:0]  ACC_RESP_OKAY       = 2'b00;
    localparam logic [1:0]  ACC_RESP_SLVERR     = 2'b10;
endpackage : acc_pkg
`default_nettype wire

// File: acc_sync.sv
// two-stage synchroniser for the raw comparator output
// assumes the raw level may change at any time relative to the clock
`timescale 1ns/1ps
`default_nettype none
module acc_sync
    import acc_pkg::*;
(
    input  wire logic core_clk_in,   // system clock
    input  wire logic nrst_in,       // synchronous reset, active low
    input  wire logic async_in,      // raw level
    output logic      sync_out       // synchronised level
);
    typedef struct packed {
        logic stage1;
        logic stage2;
    } acc_sync_t;

    acc_sync_t state;
    acc_sync_t next_state;

    always_comb begin
        next_state        = state;
        next_state.stage1 = async_in;
        next_state.stage2 = state.stage1;
    end

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.stage2;
endmodule : acc_sync
`default_nettype wire

// File: acc_edge.sv
// edge detector with mode select for the comparator interrupt event
// assumes a synchronised input level
`timescale 1ns/1ps
`default_nettype none
module acc_edge
    import acc_pkg::*;
(
    input  wire logic       core_clk_in,   // system clock
    input  wire logic       nrst_in,       // synchronous reset, active low
    input  wire logic       level_in,      // synchronised comparator output
    input  wire logic [1:0] mode_in,       // interrupt mode field
    output logic            event_out      // one-cycle event pulse
);
    typedef struct packed {
        logic prev;
    } acc_edge_t;

    acc_edge_t state;
    acc_edge_t next_state;
    logic      rise;
    logic      fall;

    always_comb begin
        next_state      = state;
        next_state.prev = level_in;
    end

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign rise = level_in & ~state.prev;
    assign fall = ~level_in & state.prev;

    always_comb begin
        unique case (mode_in)
            ACC_MODE_TOGGLE:   event_out = rise | fall;
            ACC_MODE_RESERVED: event_out = 1'b0;
            ACC_MODE_FALL:     event_out = fall;
            ACC_MODE_RISE:     event_out = rise;
        endcase
    end
endmodule : acc_edge
`default_nettype wire

// File: acc_top.sv
// analog comparator control: input selects, result sync, interrupt flag,
// capture routing and pin input buffer disables behind an AXI4-Lite slave
// assumes the comparator, converter mux and timer capture sit outside
`timescale 1ns/1ps
`default_nettype none
module acc_top
    import acc_pkg::*;
(
    input  wire logic                  core_clk_in,          // system clock
    input  wire logic                  nrst_in,              // sync reset, active low
    // axi4-lite write address
    input  wire logic                  s_axi_awvalid,        // address valid
    output logic                       s_axi_awready,        // address ready
    input  wire logic [ACC_ADDR_W-1:0] s_axi_awaddr,         // write address
    input  wire logic [2:0]            s_axi_awprot,         // unused
    // axi4-lite write data
    input  wire logic                  s_axi_wvalid,         // data valid
    output logic                       s_axi_wready,         // data ready
    input  wire logic [ACC_DATA_W-1:0] s_axi_wdata,          // write data
    input  wire logic [3:0]            s_axi_wstrb,          // byte enables
    // axi4-lite write response
    output logic                       s_axi_bvalid,         // response valid
    input  wire logic                  s_axi_bready,         // response ready
    output logic [1:0]                 s_axi_bresp,          // response code
    // axi4-lite read address
    input  wire logic                  s_axi_arvalid,        // address valid
    output logic                       s_axi_arready,        // address ready
    input  wire logic [ACC_ADDR_W-1:0] s_axi_araddr,         // read address
    input  wire logic [2:0]            s_axi_arprot,         // unused
    // axi4-lite read data
    output logic                       s_axi_rvalid,         // read valid
    input  wire logic                  s_axi_rready,         // read ready
    output logic [ACC_DATA_W-1:0]      s_axi_rdata,          // read data
    output logic [1:0]                 s_axi_rresp,          // response code
    // comparator and converter side
    input  wire logic                  comparator_raw_in,    // raw comparator output
    input  wire logic                  converter_enable_in,  // converter enabled
    input  wire logic [2:0]            channel_select_in,    // converter mux select
    output logic                       power_off_out,        // comparator powered down
    output logic                       pos_bandgap_out,      // positive input is bandgap
    output logic                       neg_use_channel_out,  // negative input from channel
    output logic [2:0]                 neg_channel_out,      // channel for negative input
    output logic                       compare_result_out,   // synchronised result
    // timer capture
    output logic                       capture_trigger_out,  // capture front-end input
    output logic                       capture_route_out,    // capture routing active
    // pins
    input  wire logic                  pos_pin_digital_in,   // positive pin digital level
    input  wire logic                  neg_pin_digital_in,   // negative pin digital level
    output logic                       pos_pin_buffer_off_out, // positive buffer disabled
    output logic                       neg_pin_buffer_off_out, // negative buffer disabled
    output logic                       pos_pin_reading_out,  // positive port reading
    output logic                       neg_pin_reading_out,  // negative port reading
    // interrupt
    input  wire logic                  global_irq_enable_in, // cpu global enable
    input  wire logic                  irq_ack_in,           // vector executed, pulse
    output logic                       irq_out               // interrupt request, level
);
    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic                  aw_held;
        logic [ACC_ADDR_W-1:0] aw_addr;
        logic                  w_held;
        logic [ACC_REG_W-1:0]  w_data;
        logic                  w_lane0;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [ACC_REG_W-1:0]  rdata;
        logic [1:0]            rresp;
        logic                  power_off;
        logic                  bandgap;
        logic                  irq_flag;
        logic                  irq_en;
        logic                  capture_en;
        logic [1:0]            irq_mode;
        logic                  mux_en;
        logic [1:0]            pin_off;
    } acc_top_t;

    acc_top_t             state;
    acc_top_t             next_state;
    logic                 result_sync;
    logic                 cmp_event;
    logic [ACC_REG_W-1:0] ctrl_view;
    logic [ACC_REG_W-1:0] conv_b_view;
    logic [ACC_REG_W-1:0] pin_dis_view;
    logic                 do_write;
    logic                 flag_clear;

    ////////////////////////////////////////////////////////////////////////////
    // result synchroniser and edge event
    acc_sync u_sync (
        .core_clk_in (core_clk_in),
        .nrst_in     (nrst_in),
        .async_in    (comparator_raw_in),
        .sync_out    (result_sync)
    );

    acc_edge u_edge (
        .core_clk_in (core_clk_in),
        .nrst_in     (nrst_in),
        .level_in    (result_sync),
        .mode_in     (state.irq_mode),
        .event_out   (cmp_event)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register views
    always_comb begin
        ctrl_view                    = '0;
        ctrl_view[ACC_BIT_POWER_OFF] = state.power_off;
        ctrl_view[ACC_BIT_BANDGAP]   = state.bandgap;
        ctrl_view[ACC_BIT_RESULT]    = result_sync;
        ctrl_view[ACC_BIT_IRQ_FLAG]  = state.irq_flag;
        ctrl_view[ACC_BIT_IRQ_EN]    = state.irq_en;
        ctrl_view[ACC_BIT_CAPTURE]   = state.capture_en;
        ctrl_view[ACC_BIT_MODE_HI]   = state.irq_mode[1];
        ctrl_view[ACC_BIT_MODE_LO]   = state.irq_mode[0];
        conv_b_view                  = '0;
        conv_b_view[ACC_BIT_MUX_EN]  = state.mux_en;
        pin_dis_view                 = '0;
        pin_dis_view[ACC_BIT_NEG_OFF] = state.pin_off[1];
        pin_dis_view[ACC_BIT_POS_OFF] = state.pin_off[0];
    end

    assign do_write   = state.aw_held & state.w_held & ~state.bvalid;
    assign flag_clear = irq_ack_in
                      | (do_write & state.w_lane0
                         & (state.aw_addr == ACC_OFS_CTRL_STATUS)
                         & state.w_data[ACC_BIT_IRQ_FLAG]);

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_state = state;
        // write address and data are taken in either order
        if (s_axi_awvalid && !state.aw_held) begin
            next_state.aw_held = 1'b1;
            next_state.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state.w_held) begin
            next_state.w_held  = 1'b1;
            next_state.w_data  = s_axi_wdata[ACC_REG_W-1:0];
            next_state.w_lane0 = s_axi_wstrb[0];
        end
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end
        if (do_write) begin
            next_state.aw_held = 1'b0;
            next_state.w_held  = 1'b0;
            next_state.bvalid  = 1'b1;
            next_state.bresp   = ACC_RESP_OKAY;
            unique case (state.aw_addr)
                ACC_OFS_CTRL_STATUS: begin
                    if (state.w_lane0) begin
                        next_state.power_off  = state.w_data[ACC_BIT_POWER_OFF];
                        next_state.bandgap    = state.w_data[ACC_BIT_BANDGAP];
                        next_state.irq_en     = state.w_data[ACC_BIT_IRQ_EN];
                        next_state.capture_en = state.w_data[ACC_BIT_CAPTURE];
                        next_state.irq_mode   = {state.w_data[ACC_BIT_MODE_HI],
                                                 state.w_data[ACC_BIT_MODE_LO]};
                    end
                end
                ACC_OFS_CONV_B: begin
                    if (state.w_lane0) begin
                        next_state.mux_en = state.w_data[ACC_BIT_MUX_EN];
                    end
                end
                ACC_OFS_PIN_DIS: begin
                    if (state.w_lane0) begin
                        next_state.pin_off = {state.w_data[ACC_BIT_NEG_OFF],
                                              state.w_data[ACC_BIT_POS_OFF]};
                    end
                end
                default: begin
                    next_state.bresp = ACC_RESP_SLVERR;
                end
            endcase
        end
        // a new event wins over a clear in the same cycle
        if (cmp_event) begin
            next_state.irq_flag = 1'b1;
        end else if (flag_clear) begin
            next_state.irq_flag = 1'b0;
        end
        // read channel
        if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !state.rvalid) begin
            next_state.rvalid = 1'b1;
            next_state.rresp  = ACC_RESP_OKAY;
            unique case (s_axi_araddr)
                ACC_OFS_CTRL_STATUS: next_state.rdata = ctrl_view;
                ACC_OFS_CONV_B:      next_state.rdata = conv_b_view;
                ACC_OFS_PIN_DIS:     next_state.rdata = pin_dis_view;
                default: begin
                    next_state.rdata = '0;
                    next_state.rresp = ACC_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) begin
            state            <= '0;
            state.power_off  <= ACC_RST_CTRL[ACC_BIT_POWER_OFF];
            state.bandgap    <= ACC_RST_CTRL[ACC_BIT_BANDGAP];
            state.irq_flag   <= ACC_RST_CTRL[ACC_BIT_IRQ_FLAG];
            state.irq_en     <= ACC_RST_CTRL[ACC_BIT_IRQ_EN];
            state.capture_en <= ACC_RST_CTRL[ACC_BIT_CAPTURE];
            state.irq_mode   <= ACC_RST_CTRL[ACC_BIT_MODE_HI:ACC_BIT_MODE_LO];
            state.mux_en     <= ACC_RST_MUX_EN;
            state.pin_off    <= ACC_RST_PIN_DIS;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign s_axi_awready = ~state.aw_held;
    assign s_axi_wready  = ~state.w_held;
    assign s_axi_bvalid  = state.bvalid;
    assign s_axi_bresp   = state.bresp;
    assign s_axi_arready = ~state.rvalid;
    assign s_axi_rvalid  = state.rvalid;
    assign s_axi_rdata   = {{(ACC_DATA_W-ACC_REG_W){1'b0}}, state.rdata};
    assign s_axi_rresp   = state.rresp;

    assign power_off_out       = state.power_off;
    assign pos_bandgap_out     = state.bandgap;
    assign neg_use_channel_out = state.mux_en & ~converter_enable_in;
    assign neg_channel_out     = neg_use_channel_out ? channel_select_in : 3'h0;
    assign compare_result_out  = result_sync;

    assign capture_route_out   = state.capture_en;
    assign capture_trigger_out = state.capture_en & result_sync;

    assign pos_pin_buffer_off_out = state.pin_off[0];
    assign neg_pin_buffer_off_out = state.pin_off[1];
    assign pos_pin_reading_out    = pos_pin_digital_in & ~state.pin_off[0];
    assign neg_pin_reading_out    = neg_pin_digital_in & ~state.pin_off[1];

    assign irq_out = state.irq_flag & state.irq_en & global_irq_enable_in;
endmodule : acc_top
`default_nettype wire

// File: acc_assertions.sv
// port-level checks for the comparator control block
// assumes it is bound to acc_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module acc_checker
    import acc_pkg::*;
(
    input wire logic                  core_clk_in,            // clock
    input wire logic                  nrst_in,                // reset, active low
    input wire logic                  comparator_raw_in,      // raw output
    input wire logic                  converter_enable_in,    // converter on
    input wire logic [2:0]            channel_select_in,      // mux select
    input wire logic                  compare_result_out,     // synced result
    input wire logic                  neg_use_channel_out,    // channel used
    input wire logic [2:0]            neg_channel_out,        // channel
    input wire logic                  capture_trigger_out,    // capture input
    input wire logic                  capture_route_out,      // capture on
    input wire logic                  pos_pin_digital_in,     // pin level
    input wire logic                  neg_pin_digital_in,     // pin level
    input wire logic                  pos_pin_buffer_off_out, // buffer off
    input wire logic                  neg_pin_buffer_off_out, // buffer off
    input wire logic                  pos_pin_reading_out,    // port reading
    input wire logic                  neg_pin_reading_out,    // port reading
    input wire logic                  global_irq_enable_in,   // global enable
    input wire logic                  irq_ack_in,             // vector taken
    input wire logic                  irq_out,                // request
    input wire logic                  s_axi_wvalid,           // write data valid
    input wire logic                  s_axi_bvalid,           // write response
    input wire logic                  s_axi_rvalid,           // read valid
    input wire logic [ACC_DATA_W-1:0] s_axi_rdata,            // read data
    input wire logic                  power_off_out,          // powered down
    input wire logic                  pos_bandgap_out         // bandgap used
);
    // counts edges since reset so the synchroniser is flushed
    logic [1:0] up_cnt;
    always_ff @(posedge core_clk_in) begin
        if (!nrst_in) up_cnt <= 2'h0;
        else if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    result_sync_a: assert property (up_cnt == 2'h3 |->
        compare_result_out == $past(comparator_raw_in, 2)) else $error("result lag wrong");
    neg_chan_a: assert property (
        neg_channel_out == (neg_use_channel_out ? channel_select_in : 3'h0))
        else $error("negative channel wrong");
    conv_on_a: assert property (converter_enable_in |-> !neg_use_channel_out)
        else $error("channel used with converter on");
    pin_read_a: assert property (
        pos_pin_reading_out == (pos_pin_digital_in && !pos_pin_buffer_off_out) &&
        neg_pin_reading_out == (neg_pin_digital_in && !neg_pin_buffer_off_out))
        else $error("pin reading wrong");
    capture_path_a: assert property (
        capture_trigger_out == (capture_route_out && compare_result_out))
        else $error("capture path wrong");
    irq_gate_a: assert property (irq_out |-> global_irq_enable_in)
        else $error("request without global enable");
    ack_clear_a: assert property (irq_ack_in && $stable(compare_result_out)
        && !s_axi_wvalid |=> !irq_out) else $error("ack did not clear");
    irq_cause_a: assert property ($rose(irq_out) && $stable(global_irq_enable_in)
        && !s_axi_bvalid |-> $past(compare_result_out) != $past(compare_result_out, 2))
        else $error("request without result edge");
    ctrl_hold_a: assert property ($changed(power_off_out) || $changed(pos_bandgap_out)
        |-> s_axi_bvalid && !$past(s_axi_bvalid)) else $error("control changed unwritten");
    rdata_high_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
endmodule : acc_checker
bind acc_top acc_checker acc_checker_inst (.*);
`default_nettype wire

// File: acc_analog_model.sv
// behavioural analog side: pin and channel voltages, the comparator
// assumes the bench sets the voltages by hierarchical reference
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model (
    input  wire logic       power_off_in, // comparator powered down
    input  wire logic       bandgap_in,   // positive input is bandgap
    input  wire logic       use_chan_in,  // negative input from channel
    input  wire logic [2:0] chan_in,      // channel for negative input
    output logic            raw_out,      // raw comparator output
    output logic            pos_dig_out,  // positive pin digital level
    output logic            neg_dig_out   // negative pin digital level
);
    int pos_mv = 500;
    int neg_mv = 1000;
    int bg_mv = 1100;
    int chan_mv [8] = '{0, 500, 1000, 1500, 2000, 2500, 3000, 3500};
    int p_mv;
    int n_mv;
    always_comb begin
        p_mv = bandgap_in ? bg_mv : pos_mv;
        n_mv = use_chan_in ? chan_mv[chan_in] : neg_mv;
        raw_out = !power_off_in && p_mv > n_mv;
        pos_dig_out = pos_mv > 2500;
        neg_dig_out = neg_mv > 2500;
    end
endmodule : acc_analog_model
`default_nettype wire

// File: analog_comparator_control_tb_top.sv
// self-checking bench for the comparator control block
// assumes acc_top, its checker bind and the analog model are compiled
`timescale 1ns/1ps
`default_nettype none
module analog_comparator_control_tb_top
    import acc_pkg::*;
;
    logic core_clk_in, nrst_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, converter_enable_in, global_irq_enable_in, irq_ack_in;
    logic [ACC_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [ACC_DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [2:0] s_axi_awprot, s_axi_arprot, channel_select_in, neg_channel_out;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic comparator_raw_in, power_off_out, pos_bandgap_out, neg_use_channel_out;
    logic compare_result_out, capture_trigger_out, capture_route_out, irq_out;
    logic pos_pin_digital_in, neg_pin_digital_in, pos_pin_buffer_off_out;
    logic neg_pin_buffer_off_out, pos_pin_reading_out, neg_pin_reading_out;
    int errors = 0;
    int samples_checked = 0;
    acc_top acc_top_inst (.*);
    acc_analog_model acc_analog_model_inst (
        .power_off_in (power_off_out),
        .bandgap_in   (pos_bandgap_out),
        .use_chan_in  (neg_use_channel_out),
        .chan_in      (neg_channel_out),
        .raw_out      (comparator_raw_in),
        .pos_dig_out  (pos_pin_digital_in),
        .neg_dig_out  (neg_pin_digital_in)
    );
    initial begin
        core_clk_in = 1'b0;
        forever #2 core_clk_in = ~core_clk_in;
    end
    ////////////////////////////////////////
    task automatic give_verdict();
        if (errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge core_clk_in);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        chk(s_axi_bresp, er);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge core_clk_in);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata, {24'h0, e});
        chk(s_axi_rresp, er);
    endtask : rd
    ////////////////////////////////////////
    task automatic t_reset();
        rd(ACC_OFS_CTRL_STATUS, 8'h00, ACC_RESP_OKAY);
        rd(ACC_OFS_CONV_B, 8'h00, ACC_RESP_OKAY);
        rd(ACC_OFS_PIN_DIS, 8'h00, ACC_RESP_OKAY);
        rd(8'h5C, 8'h00, ACC_RESP_SLVERR);
        wr(8'h5C, 8'hFF, ACC_RESP_SLVERR);
        chk(irq_out, 1'b0);
    endtask : t_reset
    task automatic t_mux();
        logic [3:0] i;
        wr(ACC_OFS_CONV_B, 8'hFF, ACC_RESP_OKAY);
        rd(ACC_OFS_CONV_B, 8'h40, ACC_RESP_OKAY);
        acc_analog_model_inst.pos_mv <= 1750;
        for (int k = 0; k < 16; k++) begin
            i = k[3:0];
            converter_enable_in <= i[3];
            channel_select_in <= i[2:0];
            cyc(4);
            chk(neg_use_channel_out, !i[3]);
            chk(neg_channel_out, i[3] ? 3'h0 : i[2:0]);
            chk(compare_result_out, i[3] || i[2:0] < 3'h4);
        end
        converter_enable_in <= 1'b0;
        wr(ACC_OFS_CONV_B, 8'h00, ACC_RESP_OKAY);
        acc_analog_model_inst.pos_mv <= 500;
        cyc(4);
        chk(neg_use_channel_out, 1'b0);
    endtask : t_mux
    task automatic t_ctrl();
        wr(ACC_OFS_CTRL_STATUS, 8'hD4, ACC_RESP_OKAY);
        cyc(4);
        chk({power_off_out, pos_bandgap_out, capture_route_out}, 3'h7);
        wr(ACC_OFS_CTRL_STATUS, 8'h44, ACC_RESP_OKAY);
        cyc(4);
        chk(compare_result_out, 1'b1);
        chk(capture_trigger_out, 1'b1);
        rd(ACC_OFS_CTRL_STATUS, 8'h74, ACC_RESP_OKAY);
        wr(ACC_OFS_CTRL_STATUS, 8'h50, ACC_RESP_OKAY);
        rd(ACC_OFS_CTRL_STATUS, 8'h60, ACC_RESP_OKAY);
        chk(capture_trigger_out, 1'b0);
        wr(ACC_OFS_CTRL_STATUS, 8'h10, ACC_RESP_OKAY);
        cyc(4);
    endtask : t_ctrl
    task automatic t_modes();
        logic [1:0] m;
        logic       hit;
        for (int k = 0; k < 4; k++) begin
            m = k[1:0];
            wr(ACC_OFS_CTRL_STATUS, {6'h04, m}, ACC_RESP_OKAY);
            wr(ACC_OFS_CTRL_STATUS, {6'h02, m}, ACC_RESP_OKAY);
            acc_analog_model_inst.pos_mv <= 1500;
            hit = m == ACC_MODE_TOGGLE || m == ACC_MODE_RISE;
            cyc(6);
            chk(irq_out, hit);
            rd(ACC_OFS_CTRL_STATUS, {3'h1, hit, 2'h2, m}, ACC_RESP_OKAY);
            global_irq_enable_in <= 1'b0;
            cyc(2);
            chk(irq_out, 1'b0);
            global_irq_enable_in <= 1'b1;
            irq_ack_in <= 1'b1;
            cyc(1);
            irq_ack_in <= 1'b0;
            cyc(1);
            chk(irq_out, 1'b0);
            acc_analog_model_inst.pos_mv <= 500;
            hit = m == ACC_MODE_TOGGLE || m == ACC_MODE_FALL;
            cyc(6);
            chk(irq_out, hit);
            wr(ACC_OFS_CTRL_STATUS, {6'h00, m}, ACC_RESP_OKAY);
        end
        wr(ACC_OFS_CTRL_STATUS, 8'h10, ACC_RESP_OKAY);
    endtask : t_modes
    task automatic t_pins();
        logic [1:0] d;
        acc_analog_model_inst.pos_mv <= 3000;
        acc_analog_model_inst.neg_mv <= 3000;
        for (int k = 0; k < 4; k++) begin
            d = k[1:0];
            wr(ACC_OFS_PIN_DIS, {6'h3F, d}, ACC_RESP_OKAY);
            rd(ACC_OFS_PIN_DIS, {6'h00, d}, ACC_RESP_OKAY);
            chk({neg_pin_buffer_off_out, pos_pin_buffer_off_out}, d);
            chk({neg_pin_reading_out, pos_pin_reading_out}, {~d});
        end
    endtask : t_pins
    ////////////////////////////////////////
    initial begin
        nrst_in = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, irq_ack_in} = 4'h0;
        {s_axi_bready, s_axi_rready, global_irq_enable_in} = 3'h7;
        {converter_enable_in, channel_select_in, s_axi_awprot, s_axi_arprot} = 10'h000;
        s_axi_wstrb = 4'hF;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0000_0000;
        cyc(8);
        nrst_in <= 1'b1;
        cyc(1);
        t_reset();
        t_mux();
        t_ctrl();
        t_modes();
        t_pins();
        give_verdict();
    end
    // cuts a hang in any bus wait
    initial begin
        cyc(5000);
        errors++;
        give_verdict();
    end
endmodule : analog_comparator_control_tb_top
`default_nettype wire
